// ### sesp_fifo2.sv
// module: two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module sesp_fifo2 #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic [W-1:0] d0;
        logic [W-1:0] d1;
        logic [1:0] cnt;
    } sesp_fifo_s;

    sesp_fifo_s st_r;
    sesp_fifo_s st_nxt;
    logic push;
    logic pop;

    assign in_ready = (st_r.cnt != 2'h2);
    assign out_valid = (st_r.cnt != 2'h0);
    assign out_data = st_r.d0;

    always_comb begin
        st_nxt = st_r;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (pop) begin
            st_nxt.d0 = st_r.d1;
            st_nxt.cnt = st_nxt.cnt - 2'h1;
        end
        if (push) begin
            if (st_nxt.cnt == 2'h0) begin
                st_nxt.d0 = in_data;
            end else begin
                st_nxt.d1 = in_data;
            end
            st_nxt.cnt = st_nxt.cnt + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// ### sesp_master.sv
// file: behavioural two-wire bus master driving the serial pins
`timescale 1ns/1ps
module sesp_master (
    // clock
    input wire logic clk,
    // bus lines
    output logic scl,
    output logic sda_drv,
    input wire logic sda_wire
);
    initial begin
        scl = 1'h1;
        sda_drv = 1'h1;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // data moves only mid low phase, sampled late in the high phase
    task automatic bit_io(input logic d, output logic q);
        cyc(5);
        sda_drv = d;
        cyc(5);
        scl = 1'h1;
        cyc(8);
        q = sda_wire;
        cyc(2);
        scl = 1'h0;
    endtask
    task automatic start();
        cyc(5);
        sda_drv = 1'h1;
        cyc(5);
        scl = 1'h1;
        cyc(10);
        sda_drv = 1'h0;
        cyc(10);
        scl = 1'h0;
    endtask
    task automatic stop();
        cyc(5);
        sda_drv = 1'h0;
        cyc(5);
        scl = 1'h1;
        cyc(10);
        sda_drv = 1'h1;
        cyc(10);
    endtask
    // ninth slot released so the pull-up shows a missing ack
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], q);
        end
        bit_io(1'h1, q);
        ack = !q;
    endtask
    task automatic rbyte(input logic mack, output logic [7:0] b);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'h1, q);
            b[i] = q;
        end
        bit_io(!mack, q);
    endtask
endmodule

// ### sesp_mem.sv
// module: small synchronous memory with registered read data
`timescale 1ns/1ps
module sesp_mem #(
    parameter int AW = 6,
    parameter int DW = 8
) (
    // clock
    input wire logic clk,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // read port
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem_q [2**AW];
    logic [DW-1:0] rdata_r;

    always_ff @(posedge clk) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
        rdata_r <= mem_q[raddr];
    end

    assign rdata = rdata_r;
endmodule

// ### sesp_pkg.sv
// package: constants and types of the serial eeprom slave front end
package sesp_pkg;

    // ----------------------------------------------------------------
    // addressing and page geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W_DEF = 15;
    localparam int ROW_LSB = 6;
    localparam int PAGE_BYTES = 64;
    localparam int BYTE_BITS = 8;
    localparam int FIFO_W = ROW_LSB + BYTE_BITS;

    // ----------------------------------------------------------------
    // select byte
    // ----------------------------------------------------------------
    localparam logic [2:0] CHIP_EN = 3'h0;
    // arbitrary device type value, not taken from any real part
    localparam logic [3:0] DEV_TYPE_DEF = 4'h5;

    // ----------------------------------------------------------------
    // timing and reset values
    // ----------------------------------------------------------------
    localparam int PROG_CYCLES_DEF = 1000;
    localparam logic SDA_OE_N_RST = 1'h1;
    localparam logic WP_RST = 1'h0;
    localparam logic LINE_RST = 1'h1;

    // ----------------------------------------------------------------
    // bit engine phases and byte kinds
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE, PH_RX, PH_ACK, PH_TX, PH_RACK
    } sesp_phase_e;
    typedef enum logic [2:0] {
        K_SEL, K_ADH, K_ADL, K_DATA, K_READ
    } sesp_kind_e;

endpackage

// ### sesp_tb.sv
// file: self-checking testbench of the serial eeprom slave front end
`timescale 1ns/1ps
module tb;
    // arbitrary device type value
    localparam logic [3:0] DT = 4'h9;
    localparam int PC = 400;
    localparam logic [7:0] SW = {DT, 3'h0, 1'h0};
    localparam logic [7:0] SR = {DT, 3'h0, 1'h1};
    logic CLK = 1'h0;
    logic RESET_N = 1'h0;
    logic WRITE_PROTECT_N = 1'h0;
    logic SCL;
    logic sda_drv;
    logic SDA_OUT;
    logic SDA_OE_N;
    logic PROG_BUSY;
    wire sda_wire = sda_drv & (SDA_OE_N ? 1'h1 : SDA_OUT);
    int mismatches = 0;
    int check_count = 0;
    int busy_len = 0;
    logic [7:0] pat [4] = '{8'ha5, 8'h3c, 8'h81, 8'h7e};
    always #2.5 CLK = ~CLK;
    always @(posedge CLK) begin
        if (PROG_BUSY === 1'h1) busy_len <= busy_len + 1;
    end
    sesp_top #(.ADDR_W(15), .PROG_CYCLES(PC), .DEV_TYPE(DT)) uut (
        .CLK(CLK), .RESET_N(RESET_N), .SCL(SCL), .SDA_IN(sda_wire),
        .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
        .WRITE_PROTECT_N(WRITE_PROTECT_N), .PROG_BUSY(PROG_BUSY));
    sesp_master m (.clk(CLK), .scl(SCL), .sda_drv(sda_drv),
        .sda_wire(sda_wire));
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic addr(input logic [7:0] hi, input logic [7:0] lo);
        logic a;
        m.start();
        m.wbyte(SW, a);
        check("select ack", 16'h1, 16'(a));
        m.wbyte(hi, a);
        check("addr hi ack", 16'h1, 16'(a));
        m.wbyte(lo, a);
        check("addr lo ack", 16'h1, 16'(a));
    endtask
    task automatic rread(input logic [7:0] lo, input int first, input int n);
        logic a;
        logic [7:0] b;
        addr(8'h12, lo);
        m.start();
        m.wbyte(SR, a);
        check("read select ack", 16'h1, 16'(a));
        for (int i = 0; i < n; i++) begin
            m.rbyte(i < n - 1, b);
            check("read data", 16'(pat[first + i]), 16'(b));
        end
        m.stop();
    endtask
    task automatic poll(output logic a);
        m.start();
        m.wbyte(SW, a);
        m.stop();
    endtask
    task automatic t_sel();
        logic a;
        logic [7:0] bad [2] = '{{~DT, 4'h0}, {DT, 4'h2}};
        for (int i = 0; i < 2; i++) begin
            m.start();
            m.wbyte(bad[i], a);
            check("foreign select ack", 16'h0, 16'(a));
            m.wbyte(8'h00, a);
            check("standby ack", 16'h0, 16'(a));
            m.stop();
        end
    endtask
    task automatic t_page();
        logic a;
        int polls;
        busy_len = 0;
        // top address bit set: must land in the same row as 0x12xx
        addr(8'h92, 8'h3e);
        for (int i = 0; i < 4; i++) begin
            m.wbyte(pat[i], a);
            check("data ack", 16'h1, 16'(a));
        end
        m.stop();
        check("busy after stop", 16'h1, 16'(PROG_BUSY));
        poll(a);
        check("poll while busy", 16'h0, 16'(a));
        polls = 0;
        while (a !== 1'h1 && polls < 10) begin
            poll(a);
            polls++;
        end
        check("poll ack", 16'h1, 16'(a));
        check("busy length", 16'(PC), 16'(busy_len));
        rread(8'h3e, 0, 2);
    endtask
    task automatic t_protect();
        logic a;
        WRITE_PROTECT_N = 1'h1;
        addr(8'h12, 8'h3e);
        // level during data is not looked at, protect stays latched
        WRITE_PROTECT_N = 1'h0;
        m.wbyte(8'h55, a);
        check("protected data ack", 16'h0, 16'(a));
        m.stop();
        m.cyc(20);
        check("busy when protected", 16'h0, 16'(PROG_BUSY));
        rread(8'h3e, 0, 1);
    endtask
    task automatic t_abort();
        logic a;
        logic q;
        logic [7:0] b;
        rread(8'h00, 2, 1);
        m.start();
        m.wbyte(SW, a);
        for (int i = 0; i < 4; i++) begin
            m.bit_io(1'h0, q);
        end
        m.start();
        WRITE_PROTECT_N = 1'h1;
        m.wbyte(SR, a);
        check("select after abort", 16'h1, 16'(a));
        m.rbyte(1'h0, b);
        check("current read", 16'(pat[3]), 16'(b));
        m.stop();
        WRITE_PROTECT_N = 1'h0;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge CLK);
        #1;
        check("drive in reset", 16'h1, 16'(SDA_OE_N));
        check("data value in reset", 16'h0, 16'(SDA_OUT));
        RESET_N = 1'h1;
        m.cyc(10);
        t_sel();
        $display("select test done");
        t_page();
        $display("page test done");
        t_protect();
        $display("protect test done");
        t_abort();
        $display("abort test done");
        conclude();
    end
    initial begin
        repeat (60000) @(posedge CLK);
        mismatches++;
        conclude();
    end
endmodule

// ### sesp_top.sv
// module: two-wire serial eeprom slave front end with page write
`timescale 1ns/1ps
module sesp_top #(
    parameter int ADDR_W = sesp_pkg::ADDR_W_DEF,
    parameter int PROG_CYCLES = sesp_pkg::PROG_CYCLES_DEF,
    parameter logic [3:0] DEV_TYPE = sesp_pkg::DEV_TYPE_DEF
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // serial bus pins
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    // write protect pin
    input wire logic WRITE_PROTECT_N,
    // status
    output logic PROG_BUSY
);
    localparam int CNT_W = $clog2(PROG_CYCLES + 1);
    localparam int RL = sesp_pkg::ROW_LSB;
    localparam int BB = sesp_pkg::BYTE_BITS;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        logic wp_m;
        logic wp_s;
        sesp_pkg::sesp_phase_e phase;
        sesp_pkg::sesp_kind_e kind;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic rw;
        logic mack;
        logic wp_seen;
        logic wr_pend;
        logic [ADDR_W-1:0] addr;
        logic [sesp_pkg::PAGE_BYTES-1:0] mask;
        logic busy;
        logic [CNT_W-1:0] cnt;
        logic cp_vld;
        logic [RL-1:0] cp_idx;
        logic sda_oe_n;
        logic sda_o;
    } sesp_state_s;

    sesp_state_s st_r;
    sesp_state_s st_nxt;

    logic rise;
    logic fall;
    logic start_det;
    logic stop_det;
    logic decide;
    logic sel_ok;
    logic trig;
    logic load_rd;
    logic ack;
    logic f_in_valid;
    logic f_in_ready;
    logic [sesp_pkg::FIFO_W-1:0] f_in_data;
    logic f_out_valid;
    logic f_out_ready;
    logic [sesp_pkg::FIFO_W-1:0] f_out_data;
    logic [BB-1:0] arr_rdata;
    logic [BB-1:0] page_rdata;
    logic arr_we;

    // ----------------------------------------------------------------
    // line events
    // ----------------------------------------------------------------
    assign rise = st_r.scl_s && !st_r.scl_p;
    assign fall = !st_r.scl_s && st_r.scl_p;
    assign start_det = st_r.scl_s && st_r.scl_p && st_r.sda_p && !st_r.sda_s;
    assign stop_det = st_r.scl_s && st_r.scl_p && !st_r.sda_p && st_r.sda_s;
    assign decide = !st_r.busy && st_r.phase == sesp_pkg::PH_RX && fall
        && st_r.bitcnt == 4'(BB);
    assign sel_ok = st_r.shift[7:1] == {DEV_TYPE, sesp_pkg::CHIP_EN};
    // stop in the slot right after a data acknowledge
    assign trig = st_r.phase == sesp_pkg::PH_RX && st_r.wr_pend
        && st_r.kind == sesp_pkg::K_DATA && st_r.bitcnt == 4'h1;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        load_rd = 1'b0;
        ack = 1'b0;
        f_in_valid = 1'b0;
        f_in_data = {st_r.addr[RL-1:0], st_r.shift};
        st_nxt.scl_m = SCL;
        st_nxt.scl_s = st_r.scl_m;
        st_nxt.scl_p = st_r.scl_s;
        st_nxt.sda_m = SDA_IN;
        st_nxt.sda_s = st_r.sda_m;
        st_nxt.sda_p = st_r.sda_s;
        st_nxt.wp_m = WRITE_PROTECT_N;
        st_nxt.wp_s = st_r.wp_m;
        st_nxt.sda_o = 1'b0;
        st_nxt.cp_vld = 1'b0;
        // page latch fill from the buffer
        if (f_out_valid && f_out_ready) begin
            st_nxt.mask[f_out_data[sesp_pkg::FIFO_W-1:BB]] = 1'b1;
        end
        if (st_r.busy) begin
            // bus is deaf while the page is copied into the array
            st_nxt.phase = sesp_pkg::PH_IDLE;
            st_nxt.sda_oe_n = 1'b1;
            st_nxt.cnt = st_r.cnt + 1'b1;
            st_nxt.cp_vld = st_r.cnt < CNT_W'(sesp_pkg::PAGE_BYTES);
            st_nxt.cp_idx = st_r.cnt[RL-1:0];
            if (st_r.cnt == CNT_W'(PROG_CYCLES - 1)) begin
                st_nxt.busy = 1'b0;
                st_nxt.mask = '0;
            end
        end else if (start_det) begin
            st_nxt.phase = sesp_pkg::PH_RX;
            st_nxt.kind = sesp_pkg::K_SEL;
            st_nxt.bitcnt = 4'h0;
            st_nxt.sda_oe_n = 1'b1;
            st_nxt.wp_seen = st_r.wp_s;
            st_nxt.wr_pend = 1'b0;
            st_nxt.mask = '0;
        end else if (stop_det) begin
            st_nxt.phase = sesp_pkg::PH_IDLE;
            st_nxt.sda_oe_n = 1'b1;
            st_nxt.wr_pend = 1'b0;
            if (trig) begin
                st_nxt.busy = 1'b1;
                st_nxt.cnt = '0;
            end else begin
                // an aborted write leaves the array untouched
                st_nxt.mask = '0;
            end
        end else begin
            case (st_r.phase)
                sesp_pkg::PH_RX: begin
                    if (st_r.wp_s && st_r.kind != sesp_pkg::K_DATA) begin
                        st_nxt.wp_seen = 1'b1;
                    end
                    if (rise) begin
                        st_nxt.shift = {st_r.shift[6:0], st_r.sda_s};
                        st_nxt.bitcnt = st_r.bitcnt + 4'h1;
                    end
                    if (decide) begin
                        st_nxt.bitcnt = 4'h0;
                        st_nxt.phase = sesp_pkg::PH_ACK;
                        case (st_r.kind)
                            sesp_pkg::K_SEL: begin
                                ack = sel_ok;
                                st_nxt.rw = st_r.shift[0];
                                if (!sel_ok) begin
                                    st_nxt.phase = sesp_pkg::PH_IDLE;
                                end
                            end
                            sesp_pkg::K_ADH: begin
                                // upper bits beyond the array are dropped
                                st_nxt.addr[ADDR_W-1:BB] =
                                    st_r.shift[ADDR_W-BB-1:0];
                                ack = 1'b1;
                            end
                            sesp_pkg::K_ADL: begin
                                st_nxt.addr[BB-1:0] = st_r.shift;
                                ack = 1'b1;
                            end
                            sesp_pkg::K_DATA: begin
                                // full buffer refuses the byte with a nack
                                if (!st_r.wp_seen && f_in_ready) begin
                                    ack = 1'b1;
                                    f_in_valid = 1'b1;
                                    st_nxt.wr_pend = 1'b1;
                                    st_nxt.addr[RL-1:0] =
                                        st_r.addr[RL-1:0] + 1'b1;
                                end
                            end
                            default: begin
                                st_nxt.phase = sesp_pkg::PH_IDLE;
                            end
                        endcase
                        st_nxt.sda_oe_n = !ack;
                    end
                end
                sesp_pkg::PH_ACK: begin
                    if (fall) begin
                        st_nxt.sda_oe_n = 1'b1;
                        st_nxt.phase = sesp_pkg::PH_RX;
                        case (st_r.kind)
                            sesp_pkg::K_SEL: begin
                                if (st_r.rw) begin
                                    load_rd = 1'b1;
                                end else begin
                                    st_nxt.kind = sesp_pkg::K_ADH;
                                end
                            end
                            sesp_pkg::K_ADH: begin
                                st_nxt.kind = sesp_pkg::K_ADL;
                            end
                            default: begin
                                st_nxt.kind = sesp_pkg::K_DATA;
                            end
                        endcase
                    end
                end
                sesp_pkg::PH_TX: begin
                    if (fall) begin
                        if (st_r.bitcnt == 4'(BB)) begin
                            st_nxt.sda_oe_n = 1'b1;
                            st_nxt.phase = sesp_pkg::PH_RACK;
                        end else begin
                            st_nxt.shift = {st_r.shift[6:0], 1'b0};
                            st_nxt.sda_oe_n = st_r.shift[6];
                            st_nxt.bitcnt = st_r.bitcnt + 4'h1;
                        end
                    end
                end
                sesp_pkg::PH_RACK: begin
                    if (rise) begin
                        st_nxt.mack = !st_r.sda_s;
                    end
                    if (fall) begin
                        if (st_r.mack) begin
                            load_rd = 1'b1;
                        end else begin
                            // master nack: wait for its stop
                            st_nxt.phase = sesp_pkg::PH_IDLE;
                        end
                    end
                end
                default: begin
                    st_nxt.sda_oe_n = 1'b1;
                end
            endcase
            if (load_rd) begin
                st_nxt.kind = sesp_pkg::K_READ;
                st_nxt.phase = sesp_pkg::PH_TX;
                st_nxt.shift = arr_rdata;
                st_nxt.sda_oe_n = arr_rdata[7];
                st_nxt.bitcnt = 4'h1;
                st_nxt.addr = st_r.addr + 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_r <= '0;
            st_r.sda_oe_n <= sesp_pkg::SDA_OE_N_RST;
            st_r.scl_m <= sesp_pkg::LINE_RST;
            st_r.scl_s <= sesp_pkg::LINE_RST;
            st_r.scl_p <= sesp_pkg::LINE_RST;
            st_r.sda_m <= sesp_pkg::LINE_RST;
            st_r.sda_s <= sesp_pkg::LINE_RST;
            st_r.sda_p <= sesp_pkg::LINE_RST;
            st_r.wp_m <= sesp_pkg::WP_RST;
            st_r.wp_s <= sesp_pkg::WP_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign SDA_OUT = st_r.sda_o;
    assign SDA_OE_N = st_r.sda_oe_n;
    assign PROG_BUSY = st_r.busy;

    // ----------------------------------------------------------------
    // data path: buffer, page latch, array
    // ----------------------------------------------------------------
    // buffer drain stalls while a page is being copied
    assign f_out_ready = !st_r.busy;
    assign arr_we = st_r.cp_vld && st_r.mask[st_r.cp_idx];

    sesp_fifo2 #(.W(sesp_pkg::FIFO_W)) u_buf (
        .clk(CLK),
        .reset_n(RESET_N),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    sesp_mem #(.AW(RL), .DW(BB)) u_page (
        .clk(CLK),
        .we(f_out_valid && f_out_ready),
        .waddr(f_out_data[sesp_pkg::FIFO_W-1:BB]),
        .wdata(f_out_data[BB-1:0]),
        .raddr(st_r.cnt[RL-1:0]),
        .rdata(page_rdata)
    );

    sesp_mem #(.AW(ADDR_W), .DW(BB)) u_array (
        .clk(CLK),
        .we(arr_we),
        .waddr({st_r.addr[ADDR_W-1:RL], st_r.cp_idx}),
        .wdata(page_rdata),
        .raddr(st_r.addr),
        .rdata(arr_rdata)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_sample;
        @(posedge CLK) disable iff (!RESET_N)
        (!st_r.busy && st_r.phase == sesp_pkg::PH_RX && rise)
        |=> st_r.shift == {$past(st_r.shift[6:0]), $past(st_r.sda_s)};
    endproperty
    a_sample: assert property (p_sample) else $error("bit not sampled");

    property p_sel_ack;
        @(posedge CLK) disable iff (!RESET_N)
        (decide && st_r.kind == sesp_pkg::K_SEL && sel_ok)
        |=> (!st_r.sda_oe_n && st_r.phase == sesp_pkg::PH_ACK) [*8];
    endproperty
    a_sel_ack: assert property (p_sel_ack) else $error("no select ack");

    property p_sel_miss;
        @(posedge CLK) disable iff (!RESET_N)
        (decide && st_r.kind == sesp_pkg::K_SEL && !sel_ok)
        |=> st_r.sda_oe_n && st_r.phase == sesp_pkg::PH_IDLE;
    endproperty
    a_sel_miss: assert property (p_sel_miss) else $error("miss not idle");

    property p_wp_nack;
        @(posedge CLK) disable iff (!RESET_N)
        (decide && st_r.kind == sesp_pkg::K_DATA && st_r.wp_seen)
        |=> st_r.sda_oe_n && $stable(st_r.addr) && !f_in_valid;
    endproperty
    a_wp_nack: assert property (p_wp_nack) else $error("protected ack");

    property p_wrap;
        @(posedge CLK) disable iff (!RESET_N)
        f_in_valid |=> st_r.addr[RL-1:0] == $past(st_r.addr[RL-1:0]) + 6'h1
        && st_r.addr[ADDR_W-1:RL] == $past(st_r.addr[ADDR_W-1:RL]);
    endproperty
    a_wrap: assert property (p_wrap) else $error("bad page increment");

    property p_trig;
        @(posedge CLK) disable iff (!RESET_N)
        (!st_r.busy && stop_det) |=> st_r.busy == $past(trig);
    endproperty
    a_trig: assert property (p_trig) else $error("bad program trigger");

    property p_deaf;
        @(posedge CLK) disable iff (!RESET_N)
        st_r.busy |=> st_r.sda_oe_n && st_r.phase == sesp_pkg::PH_IDLE;
    endproperty
    a_deaf: assert property (p_deaf) else $error("bus used while busy");

    property p_busy_len;
        @(posedge CLK) disable iff (!RESET_N)
        $rose(st_r.busy) |-> st_r.busy [*8];
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too short");

    property p_restart;
        @(posedge CLK) disable iff (!RESET_N)
        (!st_r.busy && start_det) |=> st_r.phase == sesp_pkg::PH_RX
        && st_r.kind == sesp_pkg::K_SEL && st_r.bitcnt == 4'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("start not honoured");
endmodule
